/* verilog/buck_regs_pkg.sv */
// Shared constants and carriers for the regulator command and status bank
package buck_regs_pkg;

    localparam int CH_COUNT = 3;

    // Register offsets
    localparam logic [7:0] CHANNEL1_COMMAND_OFS       = 8'h03;
    localparam logic [7:0] CHANNEL2_COMMAND_OFS       = 8'h04;
    localparam logic [7:0] CHANNEL3_COMMAND_OFS       = 8'h05;
    localparam logic [7:0] SYSTEM_CONDITION_FLAGS_OFS = 8'h06;

    // Command register field positions
    localparam int CMD_SOFT_DISABLE_BIT = 0;
    localparam int CMD_LIGHT_LOAD_BIT   = 1;
    localparam int CMD_SLEW_LSB_BIT     = 4;
    localparam int CMD_SLEW_MSB_BIT     = 6;

    // Status register field positions
    localparam int STS_OUTPUT_OK_LSB_BIT   = 0;
    localparam int STS_THERMAL_WARN_BIT    = 3;
    localparam int STS_OVERCURRENT_LSB_BIT = 4;
    localparam int STS_THERMAL_PROT_BIT    = 7;

    // Reset values
    localparam logic [7:0] CMD_RESET_VALUE    = 8'h00;
    localparam logic [7:0] STATUS_RESET_VALUE = 8'h00;
    localparam logic [7:0] READ_IDLE_VALUE    = 8'h00;

    // Slew pacing: code k gives one step per 2^k switching cycles
    localparam int          SLEW_CODE_W  = 3;
    localparam int          SLEW_CNT_W   = 7;
    localparam logic [SLEW_CNT_W-1:0] SLEW_CNT_RESET = 7'h00;

    // Command register layout, bit 7 down to bit 0
    typedef struct packed {
        logic                   spare7;
        logic [SLEW_CODE_W-1:0] slew_code;
        logic                   spare3;
        logic                   spare2;
        logic                   light_load_select;
        logic                   soft_disable;
    } cmd_reg_t;

    // Status register layout, bit 7 down to bit 0
    typedef struct packed {
        logic       thermal_protect_flag;
        logic [2:0] overcurrent_flag;
        logic       thermal_warning_flag;
        logic [2:0] output_ok;
    } status_reg_t;

    // One register access from the serial protocol engine
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage

/* verilog/slew_step_pacer.sv */
// Per-channel pacer that paces voltage-target steps from the slew code
`timescale 1ns/100ps
module slew_step_pacer
    import buck_regs_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire logic                   ce,
    input  wire logic                   tick,
    input  wire logic                   run,
    input  wire logic [SLEW_CODE_W-1:0] code,
    output logic                        step
);

    logic [SLEW_CNT_W-1:0] cnt_ff;
    logic [SLEW_CNT_W-1:0] nxt_cnt;
    logic                  step_ff;
    logic                  nxt_step;
    logic [SLEW_CNT_W-1:0] last_cnt;

    // A code change mid-interval takes effect at once; a count above the new
    // limit meets the >= compare and steps and clears on the next tick rather than wrapping round
    always_comb
    begin
        last_cnt = SLEW_CNT_W'((8'h01 << code) - 8'h01);
        nxt_cnt  = cnt_ff;
        nxt_step = 1'b0;
        if (!run)
        begin
            nxt_cnt = SLEW_CNT_RESET;
        end
        else if (tick)
        begin
            if (cnt_ff >= last_cnt)
            begin
                nxt_cnt  = SLEW_CNT_RESET;
                nxt_step = 1'b1;
            end
            else
            begin
                nxt_cnt = SLEW_CNT_W'(cnt_ff + 7'h01);
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            cnt_ff  <= SLEW_CNT_RESET;
            step_ff <= 1'b0;
        end
        else if (ce)
        begin
            cnt_ff  <= nxt_cnt;
            step_ff <= nxt_step;
        end
    end

    assign step = step_ff;

    a_step_needs_tick: assert property (@(posedge clk) disable iff (reset)
        ($rose(step_ff)) |-> $past(tick && run && ce))
        else $error("slew step without a switching tick");

    a_fast_code_step: assert property (@(posedge clk) disable iff (reset)
        (ce && tick && run && code == 3'h0) |=> step_ff)
        else $error("code zero did not step on every tick");

    a_halted_no_step: assert property (@(posedge clk) disable iff (reset)
        (ce && !run) |=> (!step_ff && cnt_ff == SLEW_CNT_RESET))
        else $error("disabled channel kept pacing");

endmodule

/* verilog/buck_command_status_regs.sv */
// Command and status register bank of a three-channel step-down regulator
// Operation
// - Three eight-bit command registers at 0x03..0x05
// - Bits 6..4 hold slew code, reset zero
// - Code k steps target every 2^k cycles
// - Bit 1: 0 pulse skipping, 1 forced PWM
// - Bit 0 high shuts the channel off
// - Read-only status register at 0x06
// - Status bit 7: over-temperature protection active
// - Status bits 6..4: channel three..one hiccup
// - Status bit 3: die above warning temperature
// - Status bits 2..0: channel three..one output good
// - Bits 7,3,2 stored, read back, no effect
// - Write lands at last data bit strobe
// - Access works unless all enable pins low
`timescale 1ns/100ps
module buck_command_status_regs
    import buck_regs_pkg::*;
(
    input  wire logic                        CLK,
    input  wire logic                        RESET,
    input  wire logic                        CE,
    input  wire reg_req_t                    REG_REQ,
    input  wire logic [CH_COUNT-1:0]         CH_HW_ENABLE_PIN,
    input  wire logic                        SW_CYCLE_TICK,
    input  wire logic                        THERMAL_PROTECT_FLAG,
    input  wire logic                        THERMAL_WARNING_FLAG,
    input  wire logic [CH_COUNT-1:0]         CH_OVERCURRENT_FLAG,
    input  wire logic [CH_COUNT-1:0]         CH_OUTPUT_OK,
    output logic [7:0]                       REG_RDATA,
    output logic                             REG_RVALID,
    output logic [CH_COUNT-1:0]              CH_SOFT_DISABLE,
    output logic [CH_COUNT-1:0]              CH_LIGHT_LOAD_SELECT,
    output logic [CH_COUNT-1:0][SLEW_CODE_W-1:0] CH_SLEW_CODE,
    output logic [CH_COUNT-1:0]              CH_SLEW_STEP
);

    cmd_reg_t    cmd_ff [CH_COUNT];
    cmd_reg_t    nxt_cmd [CH_COUNT];
    status_reg_t status_meta_ff;
    status_reg_t status_ff;
    status_reg_t status_raw;
    logic [7:0]  rdata_ff;
    logic [7:0]  nxt_rdata;
    logic        rvalid_ff;
    logic        nxt_rvalid;
    logic        access_ok;

    // Any one enable pin powers the interface; software disables do not
    assign access_ok = |CH_HW_ENABLE_PIN;

    // Monitor levels are asynchronous to the register clock
    always_comb
    begin
        status_raw.thermal_protect_flag = THERMAL_PROTECT_FLAG;
        status_raw.overcurrent_flag     = CH_OVERCURRENT_FLAG;
        status_raw.thermal_warning_flag = THERMAL_WARNING_FLAG;
        status_raw.output_ok            = CH_OUTPUT_OK;
    end

    // The first stage feeds only the second stage
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            status_meta_ff <= STATUS_RESET_VALUE;
            status_ff      <= STATUS_RESET_VALUE;
        end
        else if (CE)
        begin
            status_meta_ff <= status_raw;
            status_ff      <= status_meta_ff;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < CH_COUNT; ch++)
        begin : g_chan
            localparam logic [7:0] OFS = CHANNEL1_COMMAND_OFS + 8'(ch);

            // The protocol engine raises wr on the falling clock of the last
            // data bit, so the byte is never applied before it is complete
            always_comb
            begin
                nxt_cmd[ch] = cmd_ff[ch];
                if (REG_REQ.wr && access_ok && REG_REQ.addr == OFS)
                begin
                    nxt_cmd[ch] = cmd_reg_t'(REG_REQ.wdata);
                end
            end

            always_ff @(posedge CLK)
            begin
                if (RESET)
                begin
                    cmd_ff[ch] <= cmd_reg_t'(CMD_RESET_VALUE);
                end
                else if (CE)
                begin
                    cmd_ff[ch] <= nxt_cmd[ch];
                end
            end

            assign CH_SOFT_DISABLE[ch]      = cmd_ff[ch].soft_disable;
            assign CH_LIGHT_LOAD_SELECT[ch] = cmd_ff[ch].light_load_select;
            assign CH_SLEW_CODE[ch]         = cmd_ff[ch].slew_code;

            slew_step_pacer u_pacer (
                .clk   (CLK),
                .reset (RESET),
                .ce    (CE),
                .tick  (SW_CYCLE_TICK),
                .run   (!cmd_ff[ch].soft_disable),
                .code  (cmd_ff[ch].slew_code),
                .step  (CH_SLEW_STEP[ch])
            );

            a_write_lands: assert property (@(posedge CLK) disable iff (RESET)
                (CE && REG_REQ.wr && access_ok && REG_REQ.addr == OFS)
                |=> (cmd_ff[ch] == cmd_reg_t'($past(REG_REQ.wdata))))
                else $error("command write not applied on the strobe edge");

            a_cmd_read_back: assert property (@(posedge CLK) disable iff (RESET)
                (CE && REG_REQ.rd && !REG_REQ.wr && access_ok && REG_REQ.addr == OFS)
                |=> (REG_RVALID && REG_RDATA == 8'($past(cmd_ff[ch]))))
                else $error("command register read back wrong byte");
        end
    endgenerate

    // Register read path; unmapped and left-out offsets answer zero
    always_comb
    begin
        nxt_rdata  = rdata_ff;
        nxt_rvalid = 1'b0;
        if (REG_REQ.rd && access_ok)
        begin
            nxt_rvalid = 1'b1;
            case (REG_REQ.addr)
                CHANNEL1_COMMAND_OFS:       nxt_rdata = cmd_ff[0];
                CHANNEL2_COMMAND_OFS:       nxt_rdata = cmd_ff[1];
                CHANNEL3_COMMAND_OFS:       nxt_rdata = cmd_ff[2];
                SYSTEM_CONDITION_FLAGS_OFS: nxt_rdata = status_ff;
                default:                    nxt_rdata = READ_IDLE_VALUE;
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            rdata_ff  <= READ_IDLE_VALUE;
            rvalid_ff <= 1'b0;
        end
        else if (CE)
        begin
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    assign REG_RDATA  = rdata_ff;
    assign REG_RVALID = rvalid_ff;

    // Assertion helpers
    sequence s_status_write;
        CE && REG_REQ.wr && REG_REQ.addr == SYSTEM_CONDITION_FLAGS_OFS;
    endsequence

    sequence s_two_live_cycles;
        CE ##1 CE;
    endsequence

    sequence s_status_read;
        CE && REG_REQ.rd && access_ok && REG_REQ.addr == SYSTEM_CONDITION_FLAGS_OFS;
    endsequence

    a_status_readonly: assert property (@(posedge CLK) disable iff (RESET)
        s_status_write |=> ($stable(cmd_ff[0]) && $stable(cmd_ff[1]) && $stable(cmd_ff[2])))
        else $error("status write disturbed a command register");

    a_status_sync_lag: assert property (@(posedge CLK) disable iff (RESET)
        s_two_live_cycles |=> (status_ff == $past(status_raw, 2)))
        else $error("status did not follow monitors after two edges");

    a_status_read: assert property (@(posedge CLK) disable iff (RESET)
        s_status_read |=> (REG_RVALID && REG_RDATA == 8'($past(status_ff))))
        else $error("status read returned wrong byte");

    a_reset_clears: assert property (@(posedge CLK) disable iff (RESET)
        $fell(RESET) |-> (CH_SOFT_DISABLE == 3'h0 && CH_LIGHT_LOAD_SELECT == 3'h0
                          && CH_SLEW_CODE == 9'h000 && !REG_RVALID))
        else $error("command state not zero after reset");

    a_blocked_access: assert property (@(posedge CLK) disable iff (RESET)
        (CE && !access_ok && (REG_REQ.wr || REG_REQ.rd))
        |=> (!REG_RVALID && $stable(cmd_ff[0]) && $stable(cmd_ff[1]) && $stable(cmd_ff[2])))
        else $error("register access while all enable pins low");

    a_soft_off_access: assert property (@(posedge CLK) disable iff (RESET)
        (CE && access_ok && REG_REQ.rd && CH_SOFT_DISABLE == 3'h7) |=> REG_RVALID)
        else $error("interface stalled by software disable");

endmodule

/* tb/reg_strobe_host.sv */
// Model of the serial engine that hands whole register transfers to the bank
`timescale 1ns/100ps
module reg_strobe_host
    import buck_regs_pkg::*;
(
    input  wire logic clk,
    output reg_req_t  req
);
    initial req = '0;

    // Address byte and data byte reach the bank as one strobe after the last data bit
    task automatic issue(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{wr: w, rd: r, addr: a, wdata: d};
        @(posedge clk);
        // Released lines show the inverse so a stale value is never mistaken for a fresh one
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule

/* tb/buck_command_status_regs_tb_top.sv */
// Self-checking bench for the regulator command and status bank
`timescale 1ns/100ps
module buck_command_status_regs_tb_top
    import buck_regs_pkg::*;
;
    logic                 clk_r = 1'b0;
    logic                 reset = 1'b1;
    logic                 tick  = 1'b0;
    logic                 ce    = 1'b1;
    logic                 prot  = 1'b0;
    logic                 warn  = 1'b0;
    logic                 bad2  = 1'b0;
    logic [2:0]           hw_en = 3'b111;
    logic [2:0]           oc    = 3'b000;
    logic [2:0]           ok    = 3'b000;
    reg_req_t             req;
    logic [7:0]           rdata;
    logic                 rvalid;
    logic [2:0]           soft_dis;
    logic [2:0]           light;
    logic [2:0]           step;
    logic [2:0][2:0]      slew;
    int                   fails = 0;
    int                   comparisons = 0;
    int                   n;
    logic [7:0]           pat [2] = '{8'ha5, 8'h5a};

    always #5 clk_r = ~clk_r;

    reg_strobe_host u_host (.clk(clk_r), .req(req));

    buck_command_status_regs dut (
        .CLK(clk_r), .RESET(reset), .CE(ce), .REG_REQ(req), .CH_HW_ENABLE_PIN(hw_en),
        .SW_CYCLE_TICK(tick), .THERMAL_PROTECT_FLAG(prot), .THERMAL_WARNING_FLAG(warn),
        .CH_OVERCURRENT_FLAG(oc), .CH_OUTPUT_OK(ok), .REG_RDATA(rdata), .REG_RVALID(rvalid),
        .CH_SOFT_DISABLE(soft_dis), .CH_LIGHT_LOAD_SELECT(light), .CH_SLEW_CODE(slew),
        .CH_SLEW_STEP(step)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_host.issue(1'b1, 1'b0, a, d);
        #1;
    endtask

    // Read latency is fixed at one cycle, so valid is looked at in that cycle only
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic ev);
        u_host.issue(1'b0, 1'b1, a, 8'h00);
        #1;
        check({7'h00, rvalid}, {7'h00, ev});
        if (ev)
            check(rdata, exp);
    endtask

    task automatic tick_count(output int cnt);
        logic found;
        found = 1'b0;
        cnt = 0;
        while (!found && cnt < 200)
        begin
            cnt++;
            @(posedge clk_r);
            tick <= 1'b1;
            repeat (3)
            begin
                @(posedge clk_r);
                tick <= 1'b0;
                #1;
                found = found | (step[0] === 1'b1);
                bad2 = bad2 | (step[1] !== 1'b0);
            end
        end
        if (!found)
        begin
            fails++;
            tally_and_finish();
        end
    endtask

    initial
    begin
        repeat (8) @(posedge clk_r);
        reset <= 1'b0;
        @(posedge clk_r);
        #1;
        check({2'b00, soft_dis, light}, 8'h00);
        for (int i = 3; i <= 6; i++)
            rd(8'(i), 8'h00, 1'b1);
        $display("Test reset_defaults finished");

        wr(CHANNEL1_COMMAND_OFS, 8'h71);
        check({5'h00, slew[0]}, 8'h07);
        wr(CHANNEL2_COMMAND_OFS, 8'h8e);
        wr(CHANNEL3_COMMAND_OFS, 8'h23);
        check({2'b00, soft_dis, light}, 8'h2e);
        check({5'h00, slew[2]}, 8'h02);
        rd(CHANNEL1_COMMAND_OFS, 8'h71, 1'b1);
        rd(CHANNEL2_COMMAND_OFS, 8'h8e, 1'b1);
        rd(CHANNEL3_COMMAND_OFS, 8'h23, 1'b1);
        $display("Test command_readback finished");

        wr(SYSTEM_CONDITION_FLAGS_OFS, 8'hff);
        rd(SYSTEM_CONDITION_FLAGS_OFS, 8'h00, 1'b1);
        wr(8'h07, 8'hff);
        rd(8'h00, 8'h00, 1'b1);
        rd(CHANNEL3_COMMAND_OFS, 8'h23, 1'b1);
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk_r);
            {prot, oc, warn, ok} <= pat[i];
            repeat (3) @(posedge clk_r);
            rd(SYSTEM_CONDITION_FLAGS_OFS, pat[i], 1'b1);
        end
        $display("Test status_flags finished");

        @(posedge clk_r);
        hw_en <= 3'b000;
        wr(CHANNEL1_COMMAND_OFS, 8'h12);
        rd(CHANNEL1_COMMAND_OFS, 8'h00, 1'b0);
        @(posedge clk_r);
        hw_en <= 3'b100;
        rd(CHANNEL1_COMMAND_OFS, 8'h71, 1'b1);
        wr(CHANNEL1_COMMAND_OFS, 8'h01);
        wr(CHANNEL2_COMMAND_OFS, 8'h8f);
        check({5'h00, soft_dis}, 8'h07);
        rd(CHANNEL2_COMMAND_OFS, 8'h8f, 1'b1);
        // A strobe met with the clock enable low must leave the register untouched
        @(posedge clk_r);
        ce <= 1'b0;
        wr(CHANNEL3_COMMAND_OFS, 8'h00);
        @(posedge clk_r);
        ce <= 1'b1;
        rd(CHANNEL3_COMMAND_OFS, 8'h23, 1'b1);
        $display("Test enable_pins finished");

        // Channel two stays off through the pacing run and must never step
        wr(CHANNEL2_COMMAND_OFS, 8'h01);
        for (int k = 0; k < 8; k++)
        begin
            wr(CHANNEL1_COMMAND_OFS, {1'b0, 3'(k), 4'h0});
            tick_count(n);
            check(n[7:0], 8'(1 << k));
        end
        check({7'h00, bad2}, 8'h00);
        $display("Test slew_pacing finished");
        tally_and_finish();
    end
endmodule
